// [hdl/fpwd_pkg.sv]
// Constants, register map and reset values of the fixed period watchdog.
// Assumes one 250 MHz reference clock and 8-bit I/O port accesses on that clock.
package fpwd_pkg;

   localparam int unsigned FPWD_ADDR_W = 16;
   localparam int unsigned FPWD_DATA_W = 8;

   localparam logic [FPWD_ADDR_W-1:0] FPWD_ENABLE_CTL_ADDR = 16'h118e;
   localparam logic [FPWD_ADDR_W-1:0] FPWD_SERVICE_LAMP_CTL_ADDR = 16'h11b8;

   localparam int unsigned FPWD_ENABLE_N_BIT = 6;
   localparam int unsigned FPWD_SERVICE_TOGGLE_BIT = 6;
   localparam int unsigned FPWD_LAMP_TWO_ON_BIT = 7;

   localparam logic [FPWD_DATA_W-1:0] FPWD_ENABLE_CTL_RESET = 8'h40;
   localparam logic [FPWD_DATA_W-1:0] FPWD_SERVICE_LAMP_CTL_RESET = 8'h00;
   localparam logic [FPWD_DATA_W-1:0] FPWD_UNMAPPED_READ = 8'hff;

   localparam int unsigned FPWD_CLK_MHZ = 250;
   localparam int unsigned FPWD_TIMEOUT_MS = 1600;
   localparam int unsigned FPWD_TIMEOUT_CYCLES = FPWD_TIMEOUT_MS * 1000 * FPWD_CLK_MHZ;

   typedef logic [FPWD_ADDR_W-1:0] fpwd_addr_t;
   typedef logic [FPWD_DATA_W-1:0] fpwd_data_t;

   typedef enum logic [1:0] {
      FPWD_ST_OFF,
      FPWD_ST_COUNT,
      FPWD_ST_FIRED
   } fpwd_state_t;

endpackage

// [hdl/fpwd_tick_if.sv]
// Link between the watchdog control logic and its timeout counter.
// Assumes both ends run on the same clock.
interface fpwd_tick_if;
   logic run;
   logic restart;
   logic expire;

   modport ctl (output run, output restart, input expire);
   modport tmr (input run, input restart, output expire);
endinterface

// [hdl/fpwd_timer.sv]
// Timeout counter of the fixed period watchdog.
// Assumes run and restart come from logic on the same clock.
module fpwd_timer #(
   parameter int unsigned TIMEOUT_CYCLES = fpwd_pkg::FPWD_TIMEOUT_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   fpwd_tick_if.tmr tick
);
   import fpwd_pkg::*;

   localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

   logic [CNT_W-1:0] count_r;
   logic expire_r;

   generate
      if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
         $error("Timeout must span at least two clock cycles.");
      end
   endgenerate

   // The count runs only while enabled; a restart forces it back to zero.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn || !tick.run || tick.restart) begin
         count_r <= '0;
      end else if (count_r == CNT_LAST) begin
         count_r <= '0;
      end else begin
         count_r <= count_r + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         expire_r <= 1'b0;
      end else begin
         expire_r <= tick.run && !tick.restart && (count_r == CNT_LAST);
      end
   end

   assign tick.expire = expire_r;

endmodule

// [hdl/fpwd_top.sv]
// Fixed period watchdog with its two 8-bit I/O port control registers.
// Assumes the I/O strobes, address and data are synchronous to i_ref_clk.
module fpwd_top #(
   parameter int unsigned TIMEOUT_CYCLES = fpwd_pkg::FPWD_TIMEOUT_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire fpwd_pkg::fpwd_addr_t i_io_addr,
   input wire fpwd_pkg::fpwd_data_t i_io_wdata,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   output logic [fpwd_pkg::FPWD_DATA_W-1:0] o_io_rdata,
   output logic o_io_ack,
   output logic o_user_lamp_two,
   output logic o_watchdog_running,
   output logic o_sys_reset_req
);
   import fpwd_pkg::*;

   fpwd_data_t enable_ctl_r;
   fpwd_data_t service_lamp_ctl_r;
   fpwd_data_t rdata_r;
   logic ack_r;
   logic lamp_r;
   logic running_r;
   logic reset_req_r;
   logic restart_r;
   fpwd_state_t state_r;
   fpwd_state_t state_nxt;

   logic wr_enable_ctl;
   logic wr_service_lamp_ctl;
   logic enable_req;
   logic service_evt;

   fpwd_tick_if tick ();

   function automatic logic addr_hit(input fpwd_addr_t addr, input fpwd_addr_t reg_addr);
      addr_hit = (addr == reg_addr);
   endfunction

   function automatic logic mapped(input fpwd_addr_t addr);
      mapped = addr_hit(addr, FPWD_ENABLE_CTL_ADDR) || addr_hit(addr, FPWD_SERVICE_LAMP_CTL_ADDR);
   endfunction

   assign wr_enable_ctl = i_io_wr && addr_hit(i_io_addr, FPWD_ENABLE_CTL_ADDR);
   assign wr_service_lamp_ctl = i_io_wr && addr_hit(i_io_addr, FPWD_SERVICE_LAMP_CTL_ADDR);

   // The enable bit is active low; a stored 1 keeps the watchdog off.
   assign enable_req = !enable_ctl_r[FPWD_ENABLE_N_BIT];

   // A write that flips the service bit, in either direction, is a service.
   assign service_evt = wr_service_lamp_ctl &&
      (i_io_wdata[FPWD_SERVICE_TOGGLE_BIT] != service_lamp_ctl_r[FPWD_SERVICE_TOGGLE_BIT]);

   // Reserved bits are stored as written so read-modify-write keeps them intact.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         enable_ctl_r <= FPWD_ENABLE_CTL_RESET;
      end else if (wr_enable_ctl) begin
         enable_ctl_r <= i_io_wdata;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         service_lamp_ctl_r <= FPWD_SERVICE_LAMP_CTL_RESET;
      end else if (wr_service_lamp_ctl) begin
         service_lamp_ctl_r <= i_io_wdata;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         lamp_r <= 1'b0;
      end else if (wr_service_lamp_ctl) begin
         lamp_r <= i_io_wdata[FPWD_LAMP_TWO_ON_BIT];
      end
   end

   // Read data is registered; addresses outside the map answer all ones.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         rdata_r <= '0;
      end else if (i_io_rd) begin
         if (addr_hit(i_io_addr, FPWD_ENABLE_CTL_ADDR)) begin
            rdata_r <= enable_ctl_r;
         end else if (addr_hit(i_io_addr, FPWD_SERVICE_LAMP_CTL_ADDR)) begin
            rdata_r <= service_lamp_ctl_r;
         end else begin
            rdata_r <= FPWD_UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (i_io_rd || i_io_wr) && mapped(i_io_addr);
      end
   end

   // Watchdog sequencing: off, counting, fired.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         FPWD_ST_OFF: begin
            if (enable_req) begin
               state_nxt = FPWD_ST_COUNT;
            end
         end
         FPWD_ST_COUNT: begin
            if (tick.expire) begin
               state_nxt = FPWD_ST_FIRED;
            end else if (!enable_req) begin
               state_nxt = FPWD_ST_OFF;
            end
         end
         FPWD_ST_FIRED: begin
            state_nxt = FPWD_ST_FIRED;
         end
         default: begin
            state_nxt = FPWD_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         state_r <= FPWD_ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The count starts from zero on entry to counting and on every service.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         restart_r <= 1'b0;
      end else begin
         restart_r <= service_evt || (state_r == FPWD_ST_OFF && enable_req);
      end
   end

   assign tick.run = (state_r == FPWD_ST_COUNT);
   assign tick.restart = restart_r;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         running_r <= 1'b0;
      end else begin
         running_r <= (state_nxt == FPWD_ST_COUNT);
      end
   end

   // The reset request holds until the system resets this block.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         reset_req_r <= 1'b0;
      end else if (state_r == FPWD_ST_COUNT && tick.expire) begin
         reset_req_r <= 1'b1;
      end
   end

   fpwd_timer #(
      .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
   ) u_timer (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .tick(tick.tmr)
   );

   assign o_io_rdata = rdata_r;
   assign o_io_ack = ack_r;
   assign o_user_lamp_two = lamp_r;
   assign o_watchdog_running = running_r;
   assign o_sys_reset_req = reset_req_r;

endmodule

// [bench/fpwd_top_sva.sv]
// Port-level assertions for the fixed period watchdog.
// Assumes it is bound to fpwd_top and sees only that module's ports.
module fpwd_top_sva #(
   parameter int unsigned TIMEOUT_CYCLES = fpwd_pkg::FPWD_TIMEOUT_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire fpwd_pkg::fpwd_addr_t i_io_addr,
   input wire fpwd_pkg::fpwd_data_t i_io_wdata,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [fpwd_pkg::FPWD_DATA_W-1:0] o_io_rdata,
   input wire logic o_io_ack,
   input wire logic o_user_lamp_two,
   input wire logic o_watchdog_running,
   input wire logic o_sys_reset_req
);
   import fpwd_pkg::*;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   logic en_a;
   logic sv_a;
   assign en_a = i_io_addr == FPWD_ENABLE_CTL_ADDR;
   assign sv_a = i_io_addr == FPWD_SERVICE_LAMP_CTL_ADDR;
   // A restart reaches the counter one register late and expiry two registers before the port.
   localparam int unsigned FIRE_AT = TIMEOUT_CYCLES + 2;
   logic svc_bit_r;
   logic svc_toggle;
   int unsigned since_r;
   assign svc_toggle = i_io_wr && sv_a && (i_io_wdata[6] != svc_bit_r);
   // Mirrors the stored service bit, so a rewrite of the same value is not taken as a service.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         svc_bit_r <= FPWD_SERVICE_LAMP_CTL_RESET[FPWD_SERVICE_TOGGLE_BIT];
      end else if (i_io_wr && sv_a) begin
         svc_bit_r <= i_io_wdata[6];
      end
   end
   // Counts cycles since the count last restarted, seen from the ports alone.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn || !o_watchdog_running || svc_toggle) begin
         since_r <= '0;
      end else begin
         since_r <= since_r + 32'h1;
      end
   end
   a_fire_on_time: assert property ($rose(o_sys_reset_req) |-> since_r == FIRE_AT)
      else $error("fire not one timeout after restart");
   a_ack_on_access: assert property ((i_io_wr || i_io_rd) && (en_a || sv_a) |=> o_io_ack)
      else $error("no ack after access");
   a_unmapped_silent: assert property ((i_io_wr || i_io_rd) && !en_a && !sv_a |=> !o_io_ack)
      else $error("ack on unmapped access");
   a_lamp_follows_bit: assert property (
      i_io_wr && sv_a |=> o_user_lamp_two == $past(i_io_wdata[7]))
      else $error("lamp differs from bit 7");
   a_enable_starts: assert property (
      i_io_wr && en_a && !i_io_wdata[6] && !o_sys_reset_req |-> ##2 o_watchdog_running)
      else $error("enable did not start count");
   a_disable_stops: assert property (
      i_io_wr && en_a && i_io_wdata[6] |-> ##2 !o_watchdog_running)
      else $error("disable did not stop count");
   a_fire_stays_set: assert property (o_sys_reset_req |=> o_sys_reset_req)
      else $error("reset request dropped");
   a_fire_from_run: assert property ($rose(o_sys_reset_req) |-> $past(o_watchdog_running))
      else $error("fired while not counting");
   a_fire_stops_run: assert property (o_sys_reset_req |-> !o_watchdog_running)
      else $error("running while fired");
   a_no_early_fire: assert property ($rose(o_watchdog_running) |=> !o_sys_reset_req [*8])
      else $error("fired too early");
   c_fire: cover property ($rose(o_sys_reset_req));
   c_lamp: cover property ($rose(o_user_lamp_two));
   c_service: cover property (i_io_wr && sv_a && o_watchdog_running);
endmodule
bind fpwd_top fpwd_top_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) fpwd_top_sva_inst (.i_ref_clk,
   .i_rstn, .i_io_addr, .i_io_wdata, .i_io_wr, .i_io_rd, .o_io_rdata, .o_io_ack,
   .o_user_lamp_two, .o_watchdog_running, .o_sys_reset_req);

// [bench/tb_fpwd_top.sv]
// Self-checking bench for the fixed period watchdog.
// Assumes fpwd_top with a 20-cycle timeout and the checker bound to it.
`define CHK(a, e) \
   begin \
      samples_checked++; \
      if ((a) !== (e)) begin \
         bad_count++; \
         $display("BAD %0t mismatch", $time); \
      end \
   end
module tb_fpwd_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fpwd_pkg::*;
   localparam int unsigned T = 20;
   localparam fpwd_addr_t ENA = FPWD_ENABLE_CTL_ADDR;
   localparam fpwd_addr_t SVC = FPWD_SERVICE_LAMP_CTL_ADDR;
   int bad_count = 0;
   int samples_checked = 0;
   logic i_ref_clk = 0;
   logic i_rstn = 0;
   fpwd_addr_t i_io_addr = '0;
   fpwd_data_t i_io_wdata = '0;
   logic i_io_wr = 0;
   logic i_io_rd = 0;
   fpwd_data_t o_io_rdata;
   logic o_io_ack, o_user_lamp_two, o_watchdog_running, o_sys_reset_req;
   always #2 i_ref_clk = ~i_ref_clk;
   fpwd_top #(.TIMEOUT_CYCLES(T)) fpwd_top_inst (.i_ref_clk, .i_rstn, .i_io_addr,
      .i_io_wdata, .i_io_wr, .i_io_rd, .o_io_rdata, .o_io_ack, .o_user_lamp_two,
      .o_watchdog_running, .o_sys_reset_req);
   task automatic cyc(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   task automatic rst();
      i_rstn = 0;
      cyc(20);
      i_rstn = 1;
   endtask
   // One access; returns in the cycle where the answer stands.
   task automatic acc(input logic w, input fpwd_addr_t a, input fpwd_data_t d);
      cyc(1);
      i_io_wr = w;
      i_io_rd = !w;
      i_io_addr = a;
      i_io_wdata = d;
      cyc(1);
      i_io_wr = 0;
      i_io_rd = 0;
   endtask
   task automatic t_reset();
      rst();
      cyc(T + 5);
      `CHK(o_sys_reset_req, 1'b0);
      acc(0, ENA, 8'h00);
      `CHK(o_io_rdata, 8'h40);
      `CHK(o_io_ack, 1'b1);
      acc(0, SVC, 8'h00);
      `CHK(o_io_rdata, 8'h00);
      `CHK(o_watchdog_running, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_lamp();
      acc(1, SVC, 8'h80);
      `CHK(o_user_lamp_two, 1'b1);
      acc(0, SVC, 8'h00);
      `CHK(o_io_rdata, 8'h80);
      acc(1, SVC, 8'h00);
      `CHK(o_user_lamp_two, 1'b0);
      acc(0, 16'h1234, 8'h00);
      `CHK(o_io_rdata, 8'hff);
      `CHK(o_io_ack, 1'b0);
      $display("test lamp done");
   endtask
   task automatic t_timeout();
      acc(1, ENA, 8'h00);
      cyc(2);
      `CHK(o_watchdog_running, 1'b1);
      cyc(T - 2);
      `CHK(o_sys_reset_req, 1'b0);
      cyc(3);
      `CHK(o_sys_reset_req, 1'b1);
      `CHK(o_watchdog_running, 1'b0);
      acc(1, ENA, 8'h40);
      cyc(2);
      `CHK(o_sys_reset_req, 1'b1);
      rst();
      $display("test timeout done");
   endtask
   task automatic t_service();
      acc(1, ENA, 8'h00);
      for (int i = 0; i < 5; i++) begin
         cyc(8);
         acc(1, SVC, i[0] ? 8'h00 : 8'h40);
      end
      `CHK(o_sys_reset_req, 1'b0);
      `CHK(o_watchdog_running, 1'b1);
      // Same value again is no toggle, so the count runs out one timeout after the last toggle.
      // A false restart here would delay the request past the point where it is checked.
      acc(1, SVC, 8'h40);
      cyc(T + 1);
      `CHK(o_sys_reset_req, 1'b1);
      rst();
      $display("test service done");
   endtask
   task automatic t_disable();
      acc(1, ENA, 8'h00);
      cyc(5);
      acc(1, ENA, 8'h40);
      cyc(2);
      `CHK(o_watchdog_running, 1'b0);
      cyc(T + 5);
      `CHK(o_sys_reset_req, 1'b0);
      $display("test disable done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      t_reset();
      t_lamp();
      t_timeout();
      t_service();
      t_disable();
      results();
   end
   initial begin
      #20000;
      bad_count++;
      results();
   end
endmodule
